// [common/pmc_pkg.sv]
// constants and types for the dual core power mode controller
// ==============================================================
// How it works
// - five power states exist, active and sleep per core and three system power-down modes.
// - each core has its own active or sleep state and may sleep whatever the other does.
// - a sleeping core has its clock gated off while peripherals and memories keep clocks.
// - in any power-down mode both cores and all peripherals outside the always-on domain are off.
// - memory retention power follows the retention set chosen for the selected mode.
// - an active core may start a power-down only while it holds power-down permission.
// - with both cores permitted, power-down starts only after each core issued its wait.
// - a core wakes from sleep on an interrupt or event latched for that core.
// - sleep wake-up is per core and leaves the other core's state untouched.
// - the system leaves a power-down mode only on a wake pin, rtc or alarm timer event.
// - waking from deep power-down applies a full chip reset and reboots.
// - rtc, alarm timer, config block, otp, backup registers and event router stay powered.
// - after any reset the system clock selects the internal rc oscillator of 12 MHz.
// - the alarm timer sets its flag when its counter reaches zero only if alarm_ie is set, and interrupts if unmasked.
package pmc_pkg;

   // ============================================================
   // register map
   localparam logic [7:0]  off_ctrl      = 8'h00;
   localparam logic [7:0]  off_retain    = 8'h04;
   localparam logic [7:0]  off_state     = 8'h08;
   localparam logic [7:0]  off_irq_stat  = 8'h0c;
   localparam logic [7:0]  off_irq_mask  = 8'h10;
   localparam logic [7:0]  off_alarm     = 8'h14;
   localparam logic [7:0]  off_wake_en   = 8'h18;

   // ctrl field positions
   localparam int          ctrl_perm0    = 0;
   localparam int          ctrl_perm1    = 1;
   localparam int          ctrl_mode_lo  = 2;
   localparam int          ctrl_alarm_ie = 4;

   // reset values
   localparam logic [31:0] rst_ctrl      = 32'h0000_0000;
   localparam logic [31:0] rst_retain    = 32'h0000_0000;
   localparam logic [15:0] rst_alarm     = 16'h0000;
   localparam logic [4:0]  rst_wake_en   = 5'h1f;
   localparam logic [3:0]  rst_mask      = 4'h0;

   // interrupt status bits
   localparam int          irq_alarm     = 0;
   localparam int          irq_wake      = 1;
   localparam int          irq_pd_entry  = 2;
   localparam int          irq_sleep     = 3;

   // power-down mode selector
   localparam logic [1:0]  mode_deep_sleep = 2'h0;
   localparam logic [1:0]  mode_power_down = 2'h1;
   localparam logic [1:0]  mode_deep_pd    = 2'h2;

   // clock source codes
   localparam logic [1:0]  clk_src_rc    = 2'h0;

   // timing
   localparam int          clk_hz        = 25_000_000;
   localparam int          rc_osc_hz     = 12_000_000;
   localparam int          alarm_tick_hz = 1_000;
   localparam int          alarm_div     = clk_hz / alarm_tick_hz;
   localparam int          settle_ns     = 1_000;
   localparam int          settle_cyc    = (settle_ns * (clk_hz / 1_000_000) + 999) / 1000;
   localparam logic [7:0]  settle_cnt    = 8'(settle_cyc);

   // system sequencer states
   typedef enum logic [4:0] {
      sys_run    = 5'b00001,
      sys_enter  = 5'b00010,
      sys_down   = 5'b00100,
      sys_power  = 5'b01000,
      sys_reboot = 5'b10000
   } sys_state_t;

endpackage

// [src/alarm_timer.sv]
// alarm down-counter used as a wake source
`timescale 1ns/1ps
module alarm_timer (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // preload
   input  wire logic        load,
   input  wire logic [15:0] load_value,
   // expiry
   output logic             expired
);

   logic [15:0] count;
   logic [15:0] prescale;
   logic        running;

   wire tick = (prescale == 16'(pmc_pkg::alarm_div - 1));

   // ============================================================
   // 1 kHz tick and down count, pulse on reaching zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count    <= pmc_pkg::rst_alarm;
         prescale <= 16'h0000;
         running  <= 1'b0;
         expired  <= 1'b0;
      end else begin
         expired  <= 1'b0;
         prescale <= tick ? 16'h0000 : prescale + 16'h0001;
         if (load) begin
            count    <= load_value;
            running  <= (load_value != 16'h0000);
            prescale <= 16'h0000;
         end else if (running && tick) begin
            count <= count - 16'h0001;
            if (count == 16'h0001) begin
               running <= 1'b0;
               expired <= 1'b1;
            end
         end
      end
   end

endmodule // alarm_timer

// [src/power_mode_controller.sv]
// power mode controller: per core sleep, system power-down and wake sequencing
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module power_mode_controller (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // core 0 / core 1 requests
   input  wire logic [1:0]  wait_for_interrupt_instruction,
   input  wire logic [1:0]  wait_for_event_instruction,
   input  wire logic [1:0]  core_interrupt_controller_wake,
   // system wake sources, asynchronous
   input  wire logic [2:0]  wake_pins,
   input  wire logic        rtc_wake,
   // power and clock controls
   output logic [1:0]       core_clk_en,
   output logic [1:0]       core_sleeping,
   output logic             core_power_en,
   output logic             periph_power_en,
   output logic             periph_clk_en,
   output logic             always_on_power_en,
   output logic [31:0]      mem_retain_en,
   output logic             chip_reset_req,
   output logic [1:0]       sys_clk_sel,
   output logic [1:0]       pd_mode,
   output logic             irq
);

   // ============================================================
   // registers and state
   logic [31:0] ctrl;
   logic [31:0] retain;
   logic [3:0]  irq_stat;
   logic [3:0]  irq_mask;
   logic [15:0] alarm_preload;
   logic [4:0]  wake_en;
   logic [1:0]  sleeping;
   logic [7:0]  settle;
   logic [1:0]  waited;
   logic        alarm_expired;
   logic [3:0]  wake_s1;
   logic [3:0]  wake_s2;
   logic [3:0]  wake_s3;
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  addr_q;
   pmc_pkg::sys_state_t state;
   pmc_pkg::sys_state_t next_state;

   // ============================================================
   // bus decode
   wire        bus_take   = hsel && hready && htrans[1];
   wire [7:0]  word_addr  = {haddr[7:2], 2'b00};
   wire        wr_ctrl    = wr_pend && (addr_q == pmc_pkg::off_ctrl);
   wire        wr_retain  = wr_pend && (addr_q == pmc_pkg::off_retain);
   wire        wr_stat    = wr_pend && (addr_q == pmc_pkg::off_irq_stat);
   wire        wr_mask    = wr_pend && (addr_q == pmc_pkg::off_irq_mask);
   wire        wr_alarm   = wr_pend && (addr_q == pmc_pkg::off_alarm);
   wire        wr_wake_en = wr_pend && (addr_q == pmc_pkg::off_wake_en);

   // control fields
   wire [1:0]  perm       = {ctrl[pmc_pkg::ctrl_perm1], ctrl[pmc_pkg::ctrl_perm0]};
   wire [1:0]  sel_mode   = ctrl[pmc_pkg::ctrl_mode_lo +: 2];
   wire        alarm_ie   = ctrl[pmc_pkg::ctrl_alarm_ie];

   // ============================================================
   // wake decoding
   wire [1:0]  wait_req   = wait_for_interrupt_instruction | wait_for_event_instruction;
   wire [3:0]  wake_rise  = wake_s2 & ~wake_s3;
   wire        sys_wake   = (|(wake_rise & wake_en[3:0])) ||
                            (alarm_expired && wake_en[4]);
   // an active core holding permission may request power-down
   wire [1:0]  pd_req     = wait_req & perm & ~sleeping;
   wire [1:0]  have_wait  = waited | pd_req;
   // every permitted core must have waited before entry
   wire        pd_go      = (perm != 2'b00) && ((have_wait & perm) == perm);
   wire        mode_ok    = (sel_mode != 2'h3);

   // ============================================================
   // interrupt events
   wire [3:0]  irq_event;
   assign irq_event[pmc_pkg::irq_alarm]    = alarm_expired && alarm_ie;
   assign irq_event[pmc_pkg::irq_wake]     = (state == pmc_pkg::sys_down) && sys_wake;
   assign irq_event[pmc_pkg::irq_pd_entry] = (state == pmc_pkg::sys_enter);
   assign irq_event[pmc_pkg::irq_sleep]    = |(wait_req & ~perm & ~sleeping);
   assign irq = |(irq_stat & irq_mask);

   // ============================================================
   // alarm timer instance
   alarm_timer u_alarm (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .load       (wr_alarm),
      .load_value (hwdata[15:0]),
      .expired    (alarm_expired)
   );

   // ============================================================
   // two flop synchronisers plus edge history on wake inputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_s1 <= 4'h0;
         wake_s2 <= 4'h0;
         wake_s3 <= 4'h0;
      end else begin
         wake_s1 <= {rtc_wake, wake_pins};
         wake_s2 <= wake_s1;
         wake_s3 <= wake_s2;
      end
   end

   // ============================================================
   // ahb address phase capture, zero wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q  <= 8'h00;
      end else begin
         wr_pend <= bus_take && hwrite;
         rd_pend <= bus_take && !hwrite;
         if (bus_take) begin
            addr_q <= word_addr;
         end
      end
   end

   // read mux, unmapped reads as zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (addr_q)
         pmc_pkg::off_ctrl:     rd_mux = ctrl;
         pmc_pkg::off_retain:   rd_mux = retain;
         pmc_pkg::off_state:    rd_mux = {20'h0, pd_mode, waited, sleeping, state, 1'b0};
         pmc_pkg::off_irq_stat: rd_mux = {28'h0, irq_stat};
         pmc_pkg::off_irq_mask: rd_mux = {28'h0, irq_mask};
         pmc_pkg::off_alarm:    rd_mux = {16'h0, alarm_preload};
         pmc_pkg::off_wake_en:  rd_mux = {27'h0, wake_en};
         default:               rd_mux = 32'h0000_0000;
      endcase
   end

   assign hrdata    = rd_pend ? rd_mux : 32'h0000_0000;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ============================================================
   // software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl          <= pmc_pkg::rst_ctrl;
         retain        <= pmc_pkg::rst_retain;
         irq_mask      <= pmc_pkg::rst_mask;
         alarm_preload <= pmc_pkg::rst_alarm;
         wake_en       <= pmc_pkg::rst_wake_en;
      end else begin
         if (wr_ctrl)    ctrl          <= {27'h0, hwdata[4:0]};
         if (wr_retain)  retain        <= hwdata;
         if (wr_mask)    irq_mask      <= hwdata[3:0];
         if (wr_alarm)   alarm_preload <= hwdata[15:0];
         if (wr_wake_en) wake_en       <= hwdata[4:0];
      end
   end

   // sticky status, set wins over write one to clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= 4'h0;
      end else begin
         irq_stat <= (irq_stat & ~(wr_stat ? hwdata[3:0] : 4'h0)) | irq_event;
      end
   end

   // ============================================================
   // per core sleep tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleeping <= 2'b00;
         waited   <= 2'b00;
      end else if (state != pmc_pkg::sys_run) begin
         sleeping <= 2'b00;
         waited   <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            // each core is handled alone, no cross term
            if (sleeping[c] && core_interrupt_controller_wake[c]) begin
               sleeping[c] <= 1'b0;
            end else if (wait_req[c] && !sleeping[c]) begin
               sleeping[c] <= 1'b1;
            end
            if (pd_req[c]) begin
               waited[c] <= 1'b1;
            end else if (!sleeping[c]) begin
               waited[c] <= waited[c] & sleeping[c];
            end
         end
      end
   end

   // ============================================================
   // system sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         pmc_pkg::sys_run:    if (pd_go && mode_ok) next_state = pmc_pkg::sys_enter;
         pmc_pkg::sys_enter:  next_state = pmc_pkg::sys_down;
         pmc_pkg::sys_down: begin
            if (sys_wake) begin
               next_state = (pd_mode == pmc_pkg::mode_deep_pd) ?
                            pmc_pkg::sys_reboot : pmc_pkg::sys_power;
            end
         end
         pmc_pkg::sys_power:  if (settle == 8'h00) next_state = pmc_pkg::sys_run;
         pmc_pkg::sys_reboot: next_state = pmc_pkg::sys_run;
         default:             next_state = pmc_pkg::sys_run;
      endcase
   end

   // sequencer state, latched mode and settle counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state   <= pmc_pkg::sys_run;
         pd_mode <= pmc_pkg::mode_deep_sleep;
         settle  <= 8'h00;
      end else begin
         state <= next_state;
         if (state == pmc_pkg::sys_run && next_state == pmc_pkg::sys_enter) begin
            pd_mode <= sel_mode;
         end
         if (next_state == pmc_pkg::sys_power && state != pmc_pkg::sys_power) begin
            settle <= pmc_pkg::settle_cnt;
         end else if (settle != 8'h00) begin
            settle <= settle - 8'h01;
         end
      end
   end

   // ============================================================
   // power, clock and reset outputs
   wire in_down  = (state == pmc_pkg::sys_enter) || (state == pmc_pkg::sys_down);
   wire core_off = in_down || (state == pmc_pkg::sys_reboot);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_clk_en        <= 2'b11;
         core_sleeping      <= 2'b00;
         core_power_en      <= 1'b1;
         periph_power_en    <= 1'b1;
         periph_clk_en      <= 1'b1;
         always_on_power_en <= 1'b1;
         mem_retain_en      <= 32'hffff_ffff;
         chip_reset_req     <= 1'b0;
         sys_clk_sel        <= pmc_pkg::clk_src_rc;
      end else begin
         // cores clocked only when awake and after power is back
         core_clk_en     <= (core_off || state == pmc_pkg::sys_power) ?
                            2'b00 : ~sleeping;
         core_sleeping   <= sleeping;
         core_power_en   <= !core_off;
         periph_power_en <= !core_off;
         periph_clk_en   <= !core_off && (state != pmc_pkg::sys_power);
         always_on_power_en <= 1'b1;
         // deep-sleep keeps all memory, power-down only the selected set, deep power-down none
         mem_retain_en   <= !core_off ? 32'hffff_ffff :
                            (pd_mode == pmc_pkg::mode_deep_sleep) ? 32'hffff_ffff :
                            (pd_mode == pmc_pkg::mode_deep_pd) ? 32'h0000_0000 :
                            retain;
         chip_reset_req  <= (state == pmc_pkg::sys_reboot);
         sys_clk_sel     <= pmc_pkg::clk_src_rc;
      end
   end

   // sys_run with per core sleep gives active and sleep; sys_down gives the three modes

endmodule // power_mode_controller

// [tb/power_mode_controller_props.sv]
// concurrent checks on the power mode controller ports
`timescale 1ns/1ps
module power_mode_controller_props (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // observed ports
   input wire logic [1:0]  core_interrupt_controller_wake,
   input wire logic [1:0]  core_clk_en,
   input wire logic        core_power_en,
   input wire logic        periph_power_en,
   input wire logic        periph_clk_en,
   input wire logic        always_on_power_en,
   input wire logic [31:0] mem_retain_en,
   input wire logic        chip_reset_req,
   input wire logic [1:0]  sys_clk_sel,
   input wire logic [1:0]  pd_mode
);
   // ============================================================
   // properties
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_rc_clock;
      sys_clk_sel == pmc_pkg::clk_src_rc;
   endproperty
   a_rc_clock: assert property (p_rc_clock) else $error("clock source not rc");

   property p_always_on;
      always_on_power_en;
   endproperty
   a_always_on: assert property (p_always_on) else $error("always-on domain off");

   property p_sleep_keeps_periph;
      $fell(core_clk_en[0]) && core_clk_en[1] |-> periph_clk_en && periph_power_en;
   endproperty
   a_sleep_keeps_periph: assert property (p_sleep_keeps_periph) else $error("periph off");

   property p_down_all_off;
      !periph_power_en |-> core_clk_en == 2'b00 && !core_power_en && !periph_clk_en;
   endproperty
   a_down_all_off: assert property (p_down_all_off) else $error("core alive in down");

   property p_clock_after_power;
      $rose(core_clk_en[0]) |-> core_power_en && periph_power_en && periph_clk_en;
   endproperty
   a_clock_after_power: assert property (p_clock_after_power) else $error("early clock");

   property p_deep_pd_no_retain;
      !periph_power_en && pd_mode == pmc_pkg::mode_deep_pd |-> mem_retain_en == 32'h0;
   endproperty
   a_deep_pd_no_retain: assert property (p_deep_pd_no_retain) else $error("retained");

   property p_reset_pulse;
      chip_reset_req |-> pd_mode == pmc_pkg::mode_deep_pd ##1 !chip_reset_req;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse) else $error("bad reset pulse");

   property p_core_wake;
      core_interrupt_controller_wake[0] && !core_clk_en[0] && periph_clk_en
         |-> ##[1:3] core_clk_en[0];
   endproperty
   a_core_wake: assert property (p_core_wake) else $error("core did not wake");

   property p_valid_mode;
      pd_mode != 2'h3;
   endproperty
   a_valid_mode: assert property (p_valid_mode) else $error("invalid mode latched");
endmodule // power_mode_controller_props

bind power_mode_controller power_mode_controller_props u_power_mode_controller_props (
   .hclk, .hresetn, .core_interrupt_controller_wake, .core_clk_en, .core_power_en,
   .periph_power_en, .periph_clk_en, .always_on_power_en, .mem_retain_en,
   .chip_reset_req, .sys_clk_sel, .pd_mode
);

// [tb/dual_core_model.sv]
// model of the two cores issuing waits and taking interrupts
`timescale 1ns/1ps
module dual_core_model (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // bench commands
   input  wire logic [1:0] cmd_wait_int,
   input  wire logic [1:0] cmd_wait_evt,
   input  wire logic [1:0] cmd_irq,
   // controller side
   input  wire logic [1:0] core_clk_en,
   output logic [1:0]      wait_int,
   output logic [1:0]      wait_evt,
   output logic [1:0]      wake
);
   // ============================================================
   // cores
   logic [1:0] pend;

   // a gated core executes nothing; interrupts stay latched till it runs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_int <= 2'h0;
         wait_evt <= 2'h0;
         pend <= 2'h0;
      end else begin
         wait_int <= cmd_wait_int & core_clk_en;
         wait_evt <= cmd_wait_evt & core_clk_en;
         pend <= (pend | cmd_irq) & ~core_clk_en;
      end
   end

   assign wake = pend;
endmodule // dual_core_model

// [tb/dual_core_power_mode_controller_tb.sv]
// self-checking bench for the dual core power mode controller
`timescale 1ns/1ps
module dual_core_power_mode_controller_tb;
   // ============================================================
   // signals
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, rtc_wake;
   logic        core_power_en, periph_power_en, periph_clk_en, always_on_power_en;
   logic        chip_reset_req;
   logic [1:0]  htrans, wait_int, wait_evt, cwake, core_clk_en, core_sleeping, sys_clk_sel;
   logic [1:0]  cmd_wait_int, cmd_wait_evt, cmd_irq, pd_mode;
   logic [2:0]  hsize, wake_pins;
   logic [31:0] haddr, hwdata, hrdata, mem_retain_en, q, r;
   int          error_cnt, cmp_count, cyc, m;
   int unsigned mdl[8];

   power_mode_controller u_power_mode_controller (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .wait_for_interrupt_instruction(wait_int), .wait_for_event_instruction(wait_evt),
      .core_interrupt_controller_wake(cwake), .wake_pins(wake_pins),
      .rtc_wake(rtc_wake), .core_clk_en(core_clk_en), .core_sleeping(core_sleeping),
      .core_power_en(core_power_en), .periph_power_en(periph_power_en),
      .periph_clk_en(periph_clk_en), .always_on_power_en(always_on_power_en),
      .mem_retain_en(mem_retain_en), .chip_reset_req(chip_reset_req),
      .sys_clk_sel(sys_clk_sel), .pd_mode(pd_mode), .irq(irq)
   );

   dual_core_model u_dual_core_model (
      .hclk(hclk), .hresetn(hresetn), .cmd_wait_int(cmd_wait_int),
      .cmd_wait_evt(cmd_wait_evt), .cmd_irq(cmd_irq), .core_clk_en(core_clk_en),
      .wait_int(wait_int), .wait_evt(wait_evt), .wake(cwake)
   );

   // clock and hang guard
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 80000) begin
         error_cnt++;
         wrap_up();
      end
   end

   // ============================================================
   // tasks
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   // one single ahb-lite transfer, read data lands in q
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk iff hreadyout === 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk iff hreadyout === 1'b1);
      q = hrdata;
   endtask

   // writes update the register model: w1c for status, none for unmapped
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      if (a == pmc_pkg::off_irq_stat) mdl[3] = mdl[3] & ~d;
      else if (a != 8'h1c) mdl[a[4:2]] = d;
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
      chk("register", mdl[a[4:2]], q);
   endtask

   // one command pulse to the cores, then time to settle
   task automatic cmd(input logic [1:0] w, input logic [1:0] f, input logic [1:0] i);
      cmd_wait_int <= w;
      cmd_wait_evt <= f;
      cmd_irq <= i;
      @(posedge hclk);
      cmd_wait_int <= 2'h0;
      cmd_wait_evt <= 2'h0;
      cmd_irq <= 2'h0;
      repeat (4) @(posedge hclk);
   endtask

   // ============================================================
   // main sequence
   initial begin
      {hresetn, hsel, hwrite, rtc_wake, htrans, cmd_wait_int, cmd_wait_evt, cmd_irq} = '0;
      {haddr, hwdata, wake_pins, error_cnt, cmp_count, cyc} = '0;
      hsize = 3'h2;
      mdl = '{default: 0};
      mdl[6] = 32'h1f;
      mdl[2] = 32'(pmc_pkg::sys_run) << 1;
      q = $urandom(32'h3e6cc659);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("clk_sel", 32'(pmc_pkg::clk_src_rc), 32'(sys_clk_sel));
      chk("always_on", 32'h1, 32'(always_on_power_en));
      for (int i = 0; i < 8; i++) rd(8'(i * 4));
      wr(8'h1c, $urandom);
      rd(8'h1c);
      r = $urandom;
      wr(pmc_pkg::off_retain, r);
      rd(pmc_pkg::off_retain);
      wr(pmc_pkg::off_irq_mask, 32'hf);
      // both cores sleep without permission, then wake one at a time
      cmd(2'b01, 2'b10, 2'b00);
      chk("clk_en", 32'h0, 32'(core_clk_en));
      chk("periph", 32'h1, 32'(periph_power_en & periph_clk_en));
      chk("sleeping", 32'h3, 32'(core_sleeping));
      mdl[2] = (32'h3 << 6) | (32'(pmc_pkg::sys_run) << 1);
      rd(pmc_pkg::off_state);
      mdl[3] = 32'h8;
      rd(pmc_pkg::off_irq_stat);
      chk("irq", 32'h1, 32'(irq));
      wr(pmc_pkg::off_irq_stat, 32'h8);
      rd(pmc_pkg::off_irq_stat);
      chk("irq", 32'h0, 32'(irq));
      cmd(2'b00, 2'b00, 2'b01);
      chk("clk_en", 32'h1, 32'(core_clk_en));
      cmd(2'b00, 2'b00, 2'b10);
      chk("clk_en", 32'h3, 32'(core_clk_en));
      // each power-down mode with its own wake source
      for (m = 0; m < 3; m++) begin
         wr(pmc_pkg::off_ctrl, 32'(m * 4 + 19));
         rd(pmc_pkg::off_ctrl);
         if (m == 1) wr(pmc_pkg::off_alarm, 32'h1);
         cmd(2'b01, 2'b00, 2'b00);
         chk("one waited", 32'h1, 32'(periph_power_en));
         cmd(2'b00, 2'b10, 2'b00);
         chk("down", 32'h0, 32'(periph_power_en));
         chk("pd_mode", 32'(m), 32'(pd_mode));
         chk("retain", m == 0 ? 32'hffff_ffff : m == 1 ? r : 32'h0, mem_retain_en);
         chk("cores", 32'h0, 32'({core_clk_en, core_power_en}));
         cmd(2'b00, 2'b00, 2'b01);
         chk("core irq", 32'h0, 32'(periph_power_en));
         if (m == 0) wake_pins <= 3'(1 << ($urandom % 3));
         if (m == 2) rtc_wake <= 1'b1;
         if (m == 2) @(posedge hclk iff chip_reset_req === 1'b1);
         @(posedge hclk iff core_power_en === 1'b1);
         chk("periph power", 32'h1, 32'(periph_power_en));
         @(posedge hclk iff core_clk_en === 2'b11);
         chk("periph clk", 32'h1, 32'(periph_clk_en));
         wake_pins <= 3'h0;
         rtc_wake <= 1'b0;
         if (m < 2) begin
            bus(1'b0, pmc_pkg::off_irq_stat, 32'h0);
            chk("pd entry", 32'h1, 32'(q[pmc_pkg::irq_pd_entry]));
            chk("alarm", 32'(m == 1), 32'(q[pmc_pkg::irq_alarm]));
            chk("wake flag", 32'h1, 32'(q[pmc_pkg::irq_wake]));
            wr(pmc_pkg::off_irq_stat, 32'hf);
            mdl[3] = 32'h0;
            rd(pmc_pkg::off_irq_stat);
         end
      end
      wrap_up();
   end
endmodule // dual_core_power_mode_controller_tb
